/* logic/pig_defs.svh */
// Purpose: offsets, reset values and field positions of the interrupt and power-good block
// Assumes: byte-wide register port behind the serial slave
// Notes:   definitions only
`ifndef PIG_DEFS_SVH
`define PIG_DEFS_SVH

// register offsets
`define PIG_ADDR_HEALTH     8'h02
`define PIG_ADDR_MASK_ONE   8'h03
`define PIG_ADDR_MASK_TWO   8'h04
`define PIG_ADDR_ACK_ONE    8'h05
`define PIG_ADDR_ACK_TWO    8'h06
`define PIG_ADDR_FAULT_MASK 8'h07

// reset values
`define PIG_RST_INT_MASK    8'hFF
`define PIG_RST_FAULT_MASK  8'h00
`define PIG_RST_BYTE        8'h00

// charger status byte fields
`define PIG_CHG_INPUT_OV    0
`define PIG_CHG_STAT_LO     1
`define PIG_CHG_STAT_HI     2
`define PIG_CHG_USB         3
`define PIG_CHG_AC          4
`define PIG_CHG_DYNAMIC_POWER_PATH_LIMIT        5
`define PIG_CHG_INPUT_SEL   6

// second cause latch fields
`define PIG_EV_CHARGER      0
`define PIG_EV_INPUT        1
`define PIG_EV_INPUT_OV     2
`define PIG_EV_ADC_RANGE    3
`define PIG_EV_ADC_DONE     4
`define PIG_EV_THERMAL      5
`define PIG_EV_GP_ONE       6
`define PIG_EV_GP_TWO       7

// width of the sampled source vector
`define PIG_SRC_W           12

`endif

/* logic/pig_pkg.sv */
// Purpose: types of the interrupt and power-good block
// Assumes: pig_defs.svh for numbers
// Notes:   one-hot controller states
package pig_pkg;

  typedef enum logic [2:0] {
    PIG_IDLE  = 3'b001,
    PIG_LATCH = 3'b010,
    PIG_PEND  = 3'b100
  } pig_state_t;

  typedef struct packed {
    pig_state_t state;
    logic [7:0] int_mask_one;
    logic [7:0] int_mask_two;
    logic [7:0] fault_mask;
    logic [7:0] cause_latch_one;
    logic [7:0] cause_latch_two;
    logic       int_n;
    logic       pg_fault;
    logic       pg_fault_event;
    logic [7:0] rd_data;
  } pig_ctl_t;

  typedef struct packed {
    logic [11:0] prev;
    logic [7:0]  pg_prev;
    logic [7:0]  pg_tog;
    logic [7:0]  ev_tog;
  } pig_det_t;

endpackage

/* logic/pig_src_if.sv */
// Purpose: toggle events passed from the source detector to the controller
// Assumes: single clock domain
// Notes:   pulses are one cycle wide
`timescale 1ns/1ns
interface pig_src_if;
  logic [7:0] pg_tog;
  logic [7:0] ev_tog;
  modport det (output pg_tog, output ev_tog);
  modport ctl (input pg_tog, input ev_tog);
endinterface

/* logic/pig_toggle.sv */
// Purpose: detect toggles of every monitored status source except the battery discharge bit
// Assumes: inputs synchronous to clk
// Notes:   nothing is reported before normal operating mode is reached
`timescale 1ns/1ns
`include "pig_defs.svh"
module pig_toggle
  import pig_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // monitored sources
  input  wire logic [7:0]  supply_fault,
  input  wire logic [7:0]  charger_status,
  input  wire logic        thermal_shutdown,
  input  wire logic        adc_done,
  input  wire logic        adc_range,
  input  wire logic        gp_pin_one,
  input  wire logic        gp_pin_two,
  input  wire logic [1:0]  gp_input_en,
  input  wire logic        normal_mode,
  // events out
  pig_src_if.det           src
);

  pig_det_t s;
  pig_det_t next_s;
  logic [`PIG_SRC_W-1:0] raw;
  logic [`PIG_SRC_W-1:0] diff;

  // battery discharge bit is never sampled so it can not oscillate requests
  assign raw = {gp_pin_two, gp_pin_one, thermal_shutdown, adc_done, adc_range,
                charger_status[6:0]}; // RULE16

  // per-bit change against last sample
  genvar gi;
  generate
    for (gi = 0; gi < `PIG_SRC_W; gi++) begin : g_diff
      assign diff[gi] = raw[gi] ^ s.prev[gi];
    end
  endgenerate

  // group changes into cause bits, only once in normal mode
  always_comb begin
    next_s        = s;
    next_s.prev    = raw;
    next_s.pg_prev = supply_fault;
    next_s.pg_tog  = 8'h00;
    next_s.ev_tog  = 8'h00;
    if (normal_mode) begin // RULE14
      next_s.pg_tog = supply_fault ^ s.pg_prev; // RULE3
      next_s.ev_tog[`PIG_EV_GP_TWO]   = diff[11] & gp_input_en[1]; // RULE4
      next_s.ev_tog[`PIG_EV_GP_ONE]   = diff[10] & gp_input_en[0]; // RULE4
      next_s.ev_tog[`PIG_EV_THERMAL]  = diff[9]; // RULE3
      next_s.ev_tog[`PIG_EV_ADC_DONE] = diff[8]; // RULE3
      next_s.ev_tog[`PIG_EV_ADC_RANGE] = diff[7]; // RULE3
      next_s.ev_tog[`PIG_EV_INPUT_OV] = diff[`PIG_CHG_INPUT_OV]; // RULE3
      next_s.ev_tog[`PIG_EV_INPUT]    = diff[`PIG_CHG_INPUT_SEL] | diff[`PIG_CHG_AC]
                                        | diff[`PIG_CHG_USB]; // RULE3
      next_s.ev_tog[`PIG_EV_CHARGER]  = diff[`PIG_CHG_DYNAMIC_POWER_PATH_LIMIT] | diff[`PIG_CHG_STAT_HI]
                                        | diff[`PIG_CHG_STAT_LO]; // RULE3
    end
  end

  // last samples and toggle pulses; previous values start at zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign src.pg_tog = s.pg_tog;
  assign src.ev_tog = s.ev_tog;

endmodule // pig_toggle

/* logic/pig_top.sv */
// Purpose: interrupt controller and supply fault masking
// Assumes: register port strobes come from a serial slave that only issues completed transfers
// Notes:   all outputs registered; masks reset to masked, fault mask to unmasked
//
// Behaviour
// (RULE1) supply health register at 0x02: bit7..5 bucks, bit4..0 regulators, 1 means fault.
// (RULE2) fault mask at 0x07, same bit order; 1 masks that supply's fault.
// (RULE3) monitor input supply, charger, thermal, adc and supply power-good sources.
// (RULE4) general pins configured as inputs raise a request on either edge.
// (RULE5) host programs interrupt masks; only unmasked sources may interrupt.
// (RULE6) unmasked toggle first sets cause latch bits, then drives interrupt low.
// (RULE7) once asserted, interrupt stays low and cause latches hold the cause.
// (RULE8) while pending, further source changes are ignored, latches not updated.
// (RULE9) host writing zero to the causing bit releases interrupt and re-enables latching.
// (RULE10) an abandoned serial transfer leaves the interrupt low.
// (RULE11) no timeout releases a pending interrupt; host must acknowledge promptly.
// (RULE12) new interrupts start only after the interrupt output is back high.
// (RULE13) unmasked out-of-regulation supply raises a fault regardless of interrupt level.
// (RULE14) status is valid only once normal operating mode is reached.
// (RULE15) toggle of unmasked supply flag signals a fault event to the sequencer.
// (RULE16) battery discharge flag never raises an interrupt.
// (RULE17) simultaneous unmasked toggles all set their latch bits together.
`timescale 1ns/1ns
`include "pig_defs.svh"
module pig_top
  import pig_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // register port
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  // monitored sources
  input  wire logic [7:0]  supply_fault,
  input  wire logic [7:0]  charger_status,
  input  wire logic        thermal_shutdown,
  input  wire logic        adc_done,
  input  wire logic        adc_range,
  input  wire logic        gp_pin_one,
  input  wire logic        gp_pin_two,
  input  wire logic [1:0]  gp_input_en,
  input  wire logic        normal_mode,
  // host interrupt and sequencer
  output logic             int_n,
  output logic             pg_fault,
  output logic             pg_fault_event
);

  pig_ctl_t  s;
  pig_ctl_t  next_s;
  pig_src_if src ();
  logic [7:0] hit_one;
  logic [7:0] hit_two;
  logic       wr_ack_one;
  logic       wr_ack_two;

  pig_toggle u_toggle (
    .clk              (clk),
    .nrst             (nrst),
    .supply_fault     (supply_fault),
    .charger_status   (charger_status),
    .thermal_shutdown (thermal_shutdown),
    .adc_done         (adc_done),
    .adc_range        (adc_range),
    .gp_pin_one       (gp_pin_one),
    .gp_pin_two       (gp_pin_two),
    .gp_input_en      (gp_input_en),
    .normal_mode      (normal_mode),
    .src              (src)
  );

  // unmasked toggles of this cycle
  assign hit_one    = src.pg_tog & ~s.int_mask_one; // RULE5
  assign hit_two    = src.ev_tog & ~s.int_mask_two; // RULE5
  assign wr_ack_one = reg_wr && (reg_addr == `PIG_ADDR_ACK_ONE);
  assign wr_ack_two = reg_wr && (reg_addr == `PIG_ADDR_ACK_TWO);

  // next state: register writes, cause latching, interrupt sequencing
  always_comb begin
    next_s = s;
    next_s.pg_fault_event = |(src.pg_tog & ~s.fault_mask); // RULE15
    next_s.pg_fault = normal_mode & (|(supply_fault & ~s.fault_mask)); // RULE13
    if (reg_wr) begin
      case (reg_addr)
        `PIG_ADDR_MASK_ONE:   next_s.int_mask_one = reg_wdata;
        `PIG_ADDR_MASK_TWO:   next_s.int_mask_two = reg_wdata;
        `PIG_ADDR_FAULT_MASK: next_s.fault_mask = reg_wdata; // RULE2
        default:              next_s.int_mask_one = s.int_mask_one;
      endcase
    end
    // writes can only clear latch bits
    if (wr_ack_one) next_s.cause_latch_one = s.cause_latch_one & reg_wdata; // RULE9
    if (wr_ack_two) next_s.cause_latch_two = s.cause_latch_two & reg_wdata; // RULE9
    case (s.state)
      PIG_IDLE: begin
        // all simultaneous causes latch together; a set beats a same-cycle clear
        if ((|hit_one) || (|hit_two)) begin
          next_s.cause_latch_one = next_s.cause_latch_one | hit_one; // RULE17
          next_s.cause_latch_two = next_s.cause_latch_two | hit_two; // RULE17
          next_s.state = PIG_LATCH; // RULE6
        end
      end
      PIG_LATCH: begin
        next_s.int_n = 1'b0; // RULE6
        next_s.state = PIG_PEND;
      end
      PIG_PEND: begin // RULE7 RULE8
        // only a completed acknowledge write releases; no timeout exists
        if ((wr_ack_one || wr_ack_two) && (next_s.cause_latch_one == 8'h00)
            && (next_s.cause_latch_two == 8'h00)) begin // RULE9 RULE10 RULE11
          next_s.int_n = 1'b1;
          next_s.state = PIG_IDLE; // RULE12
        end
      end
      default: begin
        next_s.state = PIG_IDLE;
        next_s.int_n = 1'b1;
      end
    endcase
    // read data, unmapped offsets read zero
    if (reg_rd) begin
      case (reg_addr)
        `PIG_ADDR_HEALTH:     next_s.rd_data = normal_mode ? supply_fault : 8'h00; // RULE1 RULE14
        `PIG_ADDR_MASK_ONE:   next_s.rd_data = s.int_mask_one;
        `PIG_ADDR_MASK_TWO:   next_s.rd_data = s.int_mask_two;
        `PIG_ADDR_ACK_ONE:    next_s.rd_data = s.cause_latch_one;
        `PIG_ADDR_ACK_TWO:    next_s.rd_data = s.cause_latch_two;
        `PIG_ADDR_FAULT_MASK: next_s.rd_data = s.fault_mask;
        default:              next_s.rd_data = 8'h00;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s.state           <= PIG_IDLE;
      s.int_mask_one    <= `PIG_RST_INT_MASK;
      s.int_mask_two    <= `PIG_RST_INT_MASK;
      s.fault_mask      <= `PIG_RST_FAULT_MASK;
      s.cause_latch_one <= `PIG_RST_BYTE;
      s.cause_latch_two <= `PIG_RST_BYTE;
      s.int_n           <= 1'b1;
      s.pg_fault        <= 1'b0;
      s.pg_fault_event  <= 1'b0;
      s.rd_data         <= `PIG_RST_BYTE;
    end else begin
      s <= next_s;
    end
  end

  assign int_n          = s.int_n;
  assign pg_fault       = s.pg_fault;
  assign pg_fault_event = s.pg_fault_event;
  assign reg_rdata      = s.rd_data;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_cause_first;
    $fell(int_n) |-> $past(|{s.cause_latch_one, s.cause_latch_two});
  endproperty
  a_cause_first: assert property (p_cause_first) else $error("interrupt without cause"); // RULE6

  property p_hit_to_int;
    (s.state == PIG_IDLE) && ((|hit_one) || (|hit_two)) |-> ##2 !int_n;
  endproperty
  a_hit_to_int: assert property (p_hit_to_int) else $error("interrupt late"); // RULE6

  property p_hold_low;
    !int_n && !wr_ack_one && !wr_ack_two |=> !int_n;
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("interrupt released early"); // RULE7

  property p_frozen;
    (s.state == PIG_PEND) && !wr_ack_one && !wr_ack_two
      |=> $stable(s.cause_latch_one) && $stable(s.cause_latch_two);
  endproperty
  a_frozen: assert property (p_frozen) else $error("cause latch moved while pending"); // RULE8

  property p_release;
    (s.state == PIG_PEND) && wr_ack_one && ((s.cause_latch_one & reg_wdata) == 8'h00)
      && (s.cause_latch_two == 8'h00) |=> int_n && (s.state == PIG_IDLE);
  endproperty
  a_release: assert property (p_release) else $error("acknowledge did not release"); // RULE9

  property p_no_restart;
    (s.state == PIG_PEND) |=> (s.state != PIG_LATCH);
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("new request while pending"); // RULE12

  property p_masked_clean;
    (s.state == PIG_IDLE) ##1 (s.state == PIG_LATCH)
      |-> ((s.cause_latch_one & $past(s.int_mask_one)) == 8'h00)
          && ((s.cause_latch_two & $past(s.int_mask_two)) == 8'h00);
  endproperty
  a_masked_clean: assert property (p_masked_clean) else $error("masked source latched"); // RULE5

  property p_pg_level;
    normal_mode && (|(supply_fault & ~s.fault_mask)) |=> pg_fault;
  endproperty
  a_pg_level: assert property (p_pg_level) else $error("supply fault not raised"); // RULE13

  property p_pg_event;
    (|(src.pg_tog & ~s.fault_mask)) |=> pg_fault_event;
  endproperty
  a_pg_event: assert property (p_pg_event) else $error("fault event missing"); // RULE15

  property p_fmask_rd;
    reg_wr && (reg_addr == `PIG_ADDR_FAULT_MASK) ##1 reg_rd && !reg_wr
      && (reg_addr == `PIG_ADDR_FAULT_MASK) |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_fmask_rd: assert property (p_fmask_rd) else $error("fault mask readback wrong"); // RULE2

  c_interrupt: cover property ($fell(int_n));
  c_release:   cover property ($rose(int_n));
  c_multi:     cover property ((s.state == PIG_IDLE) && ($countones({hit_one, hit_two}) > 1));
  c_pg_fault:  cover property ($rose(pg_fault) && !int_n);

endmodule // pig_top

/* verification/pig_host_model.sv */
// Purpose: host processor model on the register port
// Assumes: one strobe per completed byte transfer
// Notes:   released address and data lines show inverted values
`timescale 1ns/1ns
`include "pig_defs.svh"
module pig_host_model (
  // clock and interrupt
  input  wire logic       clk,
  input  wire logic       int_n,
  // register port
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  // quiet port at time zero
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end
  // byte write; the host programs masks this way
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge clk);
    #1;
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask
  // byte read, data taken after the answering edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    reg_rd   = 1'b1;
    reg_addr = a;
    @(posedge clk);
    #1;
    reg_rd   = 1'b0;
    reg_addr = ~a;
    d        = reg_rdata;
  endtask
  // write then read the same offset on the very next edge
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    #1;
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge clk);
    #1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b1;
    reg_wdata = ~d;
    @(posedge clk);
    #1;
    reg_rd   = 1'b0;
    reg_addr = ~a;
    q        = reg_rdata;
  endtask
  // prompt service: zero every cause bit, no waiting for a timeout
  task automatic ack();
    if (int_n === 1'b0) begin
      wr(`PIG_ADDR_ACK_ONE, 8'h00);
      wr(`PIG_ADDR_ACK_TWO, 8'h00);
    end
  endtask
endmodule // pig_host_model

/* verification/testbench.sv */
// Purpose: self-checking bench of the interrupt and power-good block
// Assumes: host model drives the register port
// Notes:   each scenario task judges its own outcome
`timescale 1ns/1ns
`include "pig_defs.svh"
module testbench;
  logic       clk, nrst, thermal_shutdown, adc_done, adc_range;
  logic       gp_pin_one, gp_pin_two, normal_mode;
  logic       reg_wr, reg_rd, int_n, pg_fault, pg_fault_event;
  logic [1:0] gp_input_en;
  logic [7:0] supply_fault, charger_status, reg_addr, reg_wdata, reg_rdata, rv;
  int         error_cnt, compares, cycles;
  logic [7:0] exp_two [7] = '{8'h04, 8'h02, 8'h01, 8'h08, 8'h40, 8'h80, 8'h40};

  pig_top DUT (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .supply_fault(supply_fault), .charger_status(charger_status),
    .thermal_shutdown(thermal_shutdown), .adc_done(adc_done), .adc_range(adc_range),
    .gp_pin_one(gp_pin_one), .gp_pin_two(gp_pin_two), .gp_input_en(gp_input_en),
    .normal_mode(normal_mode), .int_n(int_n), .pg_fault(pg_fault),
    .pg_fault_event(pg_fault_event));
  pig_host_model host (.clk(clk), .int_n(int_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic finish_test();
    if (error_cnt == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // wait n edges, then step past them
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // reset values, and nothing reported before normal mode
  task automatic t_reset();
    chk({int_n, pg_fault, pg_fault_event}, 8'h04, "reset outputs");
    host.rd(`PIG_ADDR_MASK_ONE, rv);
    chk(rv, `PIG_RST_INT_MASK, "mask one reset");
    host.rd(`PIG_ADDR_MASK_TWO, rv);
    chk(rv, `PIG_RST_INT_MASK, "mask two reset");
    host.rd(`PIG_ADDR_FAULT_MASK, rv);
    chk(rv, `PIG_RST_FAULT_MASK, "fault mask reset");
    host.rd(8'hEE, rv);
    chk(rv, 8'h00, "unmapped");
    supply_fault = 8'h01;
    tick(2);
    chk(pg_fault, 8'h00, "fault before normal");
    host.rd(`PIG_ADDR_HEALTH, rv);
    chk(rv, 8'h00, "health before normal");
    supply_fault = 8'h00;
    tick(2);
    normal_mode = 1'b1;
    tick(3);
  endtask
  // fault mask is read-write, health register read-only
  task automatic t_regs();
    host.wr_rd(`PIG_ADDR_FAULT_MASK, 8'hA5, rv);
    chk(rv, 8'hA5, "fault mask");
    host.wr(`PIG_ADDR_FAULT_MASK, 8'h00);
    host.wr(`PIG_ADDR_HEALTH, 8'hFF);
    host.rd(`PIG_ADDR_HEALTH, rv);
    chk(rv, 8'h00, "health write");
  endtask
  // supply fault level and event toward the sequencer
  task automatic t_pg();
    supply_fault = 8'h04;
    tick(1);
    chk(pg_fault, 8'h01, "pg level");
    tick(1);
    chk(pg_fault_event, 8'h01, "pg event");
    tick(1);
    chk(pg_fault_event, 8'h00, "pg pulse");
    host.rd(`PIG_ADDR_HEALTH, rv);
    chk(rv, 8'h04, "health bit");
    host.wr(`PIG_ADDR_FAULT_MASK, 8'h04);
    tick(1);
    chk(pg_fault, 8'h00, "pg masked");
    supply_fault = 8'h00;
    tick(2);
    chk(pg_fault_event, 8'h00, "masked event");
    host.wr(`PIG_ADDR_FAULT_MASK, 8'h00);
  endtask
  // latch, hold, freeze, release and re-arm
  task automatic t_irq();
    host.wr(`PIG_ADDR_MASK_ONE, 8'h3F);
    supply_fault = 8'h80;
    tick(2);
    chk(int_n, 8'h01, "irq early");
    tick(1);
    chk(int_n, 8'h00, "irq low");
    chk(pg_fault, 8'h01, "pg during irq");
    host.rd(`PIG_ADDR_ACK_ONE, rv);
    chk(rv, 8'h80, "cause one");
    supply_fault = 8'h40;
    tick(20);
    chk(int_n, 8'h00, "irq held");
    host.rd(`PIG_ADDR_ACK_ONE, rv);
    chk(rv, 8'h80, "cause frozen");
    host.wr(`PIG_ADDR_ACK_ONE, 8'h00);
    tick(1);
    chk(int_n, 8'h01, "irq released");
    tick(5);
    chk(int_n, 8'h01, "dropped toggles");
    supply_fault = 8'h00;
    tick(4);
    chk(int_n, 8'h00, "irq again");
    host.rd(`PIG_ADDR_ACK_ONE, rv);
    chk(rv, 8'h40, "new cause");
    host.ack();
    chk(int_n, 8'h01, "ack release");
    host.wr(`PIG_ADDR_MASK_ONE, 8'hFF);
  endtask
  // every second-latch source, pin one on both edges, masks
  task automatic t_events();
    host.wr(`PIG_ADDR_MASK_TWO, 8'h00);
    charger_status[7] = 1'b1;
    tick(6);
    chk(int_n, 8'h01, "discharge");
    thermal_shutdown = 1'b1;
    adc_done = 1'b1;
    tick(4);
    chk(int_n, 8'h00, "pair irq");
    host.rd(`PIG_ADDR_ACK_TWO, rv);
    chk(rv, 8'h30, "pair cause");
    host.ack();
    gp_input_en = 2'b11;
    for (int i = 0; i < 7; i++) begin
      case (i)
        0: charger_status[0] = 1'b1;
        1: charger_status[4] = 1'b1;
        2: charger_status[1] = 1'b1;
        3: adc_range = 1'b1;
        4: gp_pin_one = 1'b1;
        5: gp_pin_two = 1'b1;
        default: gp_pin_one = 1'b0;
      endcase
      tick(4);
      chk(int_n, 8'h00, "source irq");
      host.rd(`PIG_ADDR_ACK_TWO, rv);
      chk(rv, exp_two[i], "source cause");
      host.ack();
    end
    gp_input_en = 2'b00;
    gp_pin_two = 1'b0;
    tick(6);
    chk(int_n, 8'h01, "pin disabled");
    host.wr(`PIG_ADDR_MASK_TWO, 8'hFF);
    adc_done = 1'b0;
    tick(6);
    chk(int_n, 8'h01, "masked source");
  endtask
  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      finish_test();
    end
  end
  // main sequence
  initial begin
    {nrst, thermal_shutdown, adc_done, adc_range, gp_pin_one, gp_pin_two} = '0;
    {normal_mode, gp_input_en, supply_fault, charger_status} = '0;
    {error_cnt, compares, cycles} = '0;
    repeat (4) @(posedge clk);
    #1;
    nrst = 1'b1;
    t_reset();
    t_regs();
    t_pg();
    t_irq();
    t_events();
    finish_test();
  end
endmodule // testbench
